// ### core/slc_pkg.sv
package slc_pkg;
	// ----------------------------------------
	// apb register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] SLC_OFS_MODE_A = 8'h00;
	localparam logic [7:0] SLC_OFS_CHANNEL_CONFIG_TWO_A = 8'h04;
	localparam logic [7:0] SLC_OFS_TXCNT_A = 8'h08;
	localparam logic [7:0] SLC_CHAN_STRIDE = 8'h10;
	localparam logic [7:0] SLC_OFS_INT_STAT = 8'h20;
	localparam logic [7:0] SLC_OFS_INT_CLR = 8'h24;
	localparam logic [7:0] SLC_OFS_INT_EN = 8'h28;
	localparam logic [7:0] SLC_OFS_LINE_STAT = 8'h2C;
	// ----------------------------------------
	// field positions, widths and reset values
	// ----------------------------------------
	localparam int SLC_MODE_RTS_BIT = 0;
	localparam int SLC_CCR_W = 10;
	localparam int SLC_EVT_W = 3;
	localparam int SLC_EVT_CTS = 0;
	localparam int SLC_EVT_CD = 1;
	localparam int SLC_EVT_COLL = 2;
	localparam int SLC_INT_W = 6;
	localparam int SLC_CNT_W = 16;
	localparam int SLC_BLK_W = 6;
	localparam logic [31:0] SLC_RDATA_RST = 32'h0000_0000;
	localparam logic [15:0] SLC_CNT_RST = 16'h0000;
	localparam logic [5:0] SLC_INT_RST = 6'h00;
	// ----------------------------------------
	// timing: bus-mode rts lags the frame by one clock period
	// ----------------------------------------
	localparam int SLC_MCLK_HZ = 40_000_000;
	localparam int SLC_RTS_LAG_CYCLES = 1;
	// ----------------------------------------
	// clock modes
	// ----------------------------------------
	localparam logic [2:0] SLC_CM0 = 3'h0;
	localparam logic [2:0] SLC_CM1 = 3'h1;
	localparam logic [2:0] SLC_CM2 = 3'h2;
	localparam logic [2:0] SLC_CM3 = 3'h3;
	localparam logic [2:0] SLC_CM5 = 3'h5;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		SLC_RTS_MODEM,
		SLC_RTS_TX_FRAME,
		SLC_RTS_RX_FRAME,
		SLC_RTS_OFF
	} slc_rts_cfg_e;

	// channel configuration, clk_mode in bits 2:0
	typedef struct packed {
		logic idle_fill;
		logic nrzi;
		logic autostart;
		slc_rts_cfg_e rts_cfg;
		logic open_drain;
		logic swap;
		logic [2:0] clk_mode;
	} slc_ccr_s;

	// parallel bus strobes seen by the dma path
	typedef struct packed {
		logic rd;
		logic wr;
		logic addr0;
		logic byte_high_low_enable_n;
	} slc_pbus_s;

	// bytes moved by one fifo access: word when a0 and enable are both low
	function automatic logic [1:0] slc_acc_bytes(input logic a0, input logic bhle_n);
		slc_acc_bytes = (!a0 && !bhle_n) ? 2'h2 : 2'h1;
	endfunction
endpackage

// ### core/slc_line_chan.sv
// per-channel pin roles, rts, cts, carrier detect and data pins
module slc_line_chan (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_srst,
	// configuration
	input wire slc_pkg::slc_ccr_s i_ccr,
	input wire logic i_rts_bit,
	// transmitter and receiver core
	input wire logic i_tx_serial,
	input wire logic i_tx_active,
	input wire logic i_tx_pending,
	input wire logic i_tx_collision_bit,
	input wire logic i_rx_frame,
	// line pins
	input wire logic i_rx_line_clock,
	input wire logic i_cts_n,
	input wire logic i_carrier_detect,
	input wire logic i_collision_data_in,
	input wire logic i_rxd_pin,
	input wire logic i_txd_pin,
	output logic o_rxd_pin_out,
	output logic o_rxd_pin_oe,
	output logic o_txd_pin_out,
	output logic o_txd_pin_oe,
	output logic o_rts_n,
	// to the core
	output logic o_rx_data,
	output logic o_tx_enable,
	output logic o_rx_clock,
	output logic o_txrx_clock,
	output logic o_brg_clock,
	output logic o_cd_input,
	output logic o_rx_enable,
	output logic o_rx_strobe,
	output logic o_frame_sync,
	output logic [slc_pkg::SLC_EVT_W-1:0] o_events
);
	typedef struct packed {
		logic cts_prev;
		logic cd_prev;
		logic tx_lag;
		logic rts_n;
		logic rxd_out, rxd_oe, txd_out, txd_oe;
		logic rx_data, tx_en, rx_clk, txrx_clk, brg_clk;
		logic cd_in, rx_en, rx_strobe, fsync;
		logic [slc_pkg::SLC_EVT_W-1:0] events;
	} slc_line_state_s;

	slc_line_state_s state_reg, state_next;
	logic tx_value;
	logic drive_low;

	// next state of all pin roles
	always_comb begin
		state_next = state_reg;
		state_next.cts_prev = i_cts_n;
		state_next.cd_prev = i_carrier_detect;
		state_next.tx_lag = i_tx_active && !i_tx_collision_bit;
		// rts per configuration
		case (i_ccr.rts_cfg)
			slc_pkg::SLC_RTS_MODEM: begin
				if (i_rts_bit)
					state_next.rts_n = 1'b0;
				else if (!i_tx_active && !i_tx_pending)
					state_next.rts_n = 1'b1;
			end
			slc_pkg::SLC_RTS_TX_FRAME: state_next.rts_n = !state_reg.tx_lag;
			slc_pkg::SLC_RTS_RX_FRAME: state_next.rts_n = !i_rx_frame;
			slc_pkg::SLC_RTS_OFF: state_next.rts_n = 1'b1;
			default: state_next.rts_n = 1'b1;
		endcase
		// idle fill under nrzi with rts bit clear ors in the rts level
		tx_value = i_tx_serial;
		if (i_ccr.nrzi && i_ccr.idle_fill && !i_rts_bit)
			tx_value = i_tx_serial | state_reg.rts_n;
		// open drain only pulls low, push-pull always drives
		drive_low = !tx_value;
		state_next.txd_out = i_ccr.swap ? 1'b1 : tx_value;
		state_next.txd_oe = i_ccr.swap ? 1'b0 : (!i_ccr.open_drain || drive_low);
		state_next.rxd_out = i_ccr.swap ? tx_value : 1'b1;
		state_next.rxd_oe = i_ccr.swap ? (!i_ccr.open_drain || drive_low) : 1'b0;
		state_next.rx_data = i_ccr.swap ? i_txd_pin : i_rxd_pin;
		state_next.tx_en = !i_cts_n;
		// receive clock pin role by clock mode
		state_next.rx_clk = (i_ccr.clk_mode == slc_pkg::SLC_CM0) && i_rx_line_clock;
		state_next.txrx_clk = ((i_ccr.clk_mode == slc_pkg::SLC_CM1) ||
			(i_ccr.clk_mode == slc_pkg::SLC_CM5)) && i_rx_line_clock;
		state_next.brg_clk = ((i_ccr.clk_mode == slc_pkg::SLC_CM2) ||
			(i_ccr.clk_mode == slc_pkg::SLC_CM3)) && i_rx_line_clock;
		// carrier detect role by clock mode and auto-start
		state_next.cd_in = i_carrier_detect;
		state_next.rx_en = 1'b1;
		state_next.rx_strobe = 1'b0;
		state_next.fsync = 1'b0;
		if (i_ccr.autostart) begin
			case (i_ccr.clk_mode)
				slc_pkg::SLC_CM1: state_next.rx_strobe = i_carrier_detect;
				slc_pkg::SLC_CM5: state_next.fsync = i_carrier_detect;
				default: state_next.rx_en = i_carrier_detect;
			endcase
		end
		// change events; collision when a released bit reads back low
		state_next.events[slc_pkg::SLC_EVT_CTS] = i_cts_n != state_reg.cts_prev;
		state_next.events[slc_pkg::SLC_EVT_CD] = i_carrier_detect != state_reg.cd_prev;
		state_next.events[slc_pkg::SLC_EVT_COLL] = i_ccr.open_drain && i_tx_active &&
			tx_value && !i_collision_data_in;
	end

	// state register
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			state_reg <= '0; // edge history starts at the idle pin levels
			state_reg.rts_n <= 1'b1;
			state_reg.rxd_out <= 1'b1;
			state_reg.txd_out <= 1'b1;
			state_reg.rx_en <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_rxd_pin_out = state_reg.rxd_out;
	assign o_rxd_pin_oe = state_reg.rxd_oe;
	assign o_txd_pin_out = state_reg.txd_out;
	assign o_txd_pin_oe = state_reg.txd_oe;
	assign o_rts_n = state_reg.rts_n;
	assign o_rx_data = state_reg.rx_data;
	assign o_tx_enable = state_reg.tx_en;
	assign o_rx_clock = state_reg.rx_clk;
	assign o_txrx_clock = state_reg.txrx_clk;
	assign o_brg_clock = state_reg.brg_clk;
	assign o_cd_input = state_reg.cd_in;
	assign o_rx_enable = state_reg.rx_en;
	assign o_rx_strobe = state_reg.rx_strobe;
	assign o_frame_sync = state_reg.fsync;
	assign o_events = state_reg.events;
endmodule // slc_line_chan

// ### core/slc_dma_chan.sv
// per-channel dma acknowledge decode and request generation
module slc_dma_chan (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_srst,
	// parallel bus
	input wire logic i_dma_ack_n,
	input wire slc_pkg::slc_pbus_s i_pbus,
	// byte count load
	input wire logic i_count_load,
	input wire logic [slc_pkg::SLC_CNT_W-1:0] i_count_value,
	// fifo status
	input wire logic i_tx_fifo_need,
	input wire logic i_rx_fifo_need,
	input wire logic [slc_pkg::SLC_BLK_W-1:0] i_rx_block_bytes,
	// outputs
	output logic o_fifo_access,
	output logic o_fifo_word,
	output logic o_fifo_high_byte,
	output logic o_tx_request,
	output logic o_rx_request,
	output logic [slc_pkg::SLC_CNT_W-1:0] o_tx_remaining
);
	typedef struct packed {
		logic acc_prev;
		logic rd_prev;
		logic access, word, high_byte;
		logic tx_req, rx_req, rx_done;
		logic [slc_pkg::SLC_CNT_W-1:0] tx_left;
		logic [slc_pkg::SLC_BLK_W-1:0] rx_left;
	} slc_dma_state_s;

	slc_dma_state_s state_reg, state_next;
	logic acc_now;
	logic acc_start;
	logic [1:0] width;

	// acknowledge low with a strobe opens the fifo; a1..a6 never looked at
	always_comb begin
		state_next = state_reg;
		acc_now = !i_dma_ack_n && (i_pbus.rd || i_pbus.wr);
		acc_start = acc_now && !state_reg.acc_prev;
		width = slc_pkg::slc_acc_bytes(i_pbus.addr0, i_pbus.byte_high_low_enable_n);
		state_next.acc_prev = acc_now;
		state_next.rd_prev = acc_now && i_pbus.rd;
		state_next.access = acc_now;
		state_next.word = acc_now && (width == 2'h2);
		state_next.high_byte = acc_now && i_pbus.addr0;
		// transmit side: count down, drop at the start of the last write
		if (i_count_load)
			state_next.tx_left = i_count_value;
		else if (acc_start && i_pbus.wr)
			state_next.tx_left = (state_reg.tx_left > {14'h0000, width}) ?
				state_reg.tx_left - {14'h0000, width} : '0;
		state_next.tx_req = i_tx_fifo_need && (state_next.tx_left != '0);
		// receive side: block size latched while idle, drop after last read ends
		if (!state_reg.rx_req && !state_reg.rx_done)
			state_next.rx_left = i_rx_block_bytes;
		else if (acc_start && i_pbus.rd)
			state_next.rx_left = (state_reg.rx_left > {4'h0, width}) ?
				state_reg.rx_left - {4'h0, width} : '0;
		if (!i_rx_fifo_need)
			state_next.rx_done = 1'b0;
		else if (state_reg.rd_prev && !acc_now && state_reg.rx_left == '0)
			state_next.rx_done = 1'b1;
		state_next.rx_req = i_rx_fifo_need && !state_next.rx_done;
	end

	// state register
	always_ff @(posedge i_mclk) begin
		if (i_srst)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign o_fifo_access = state_reg.access;
	assign o_fifo_word = state_reg.word;
	assign o_fifo_high_byte = state_reg.high_byte;
	assign o_tx_request = state_reg.tx_req;
	assign o_rx_request = state_reg.rx_req;
	assign o_tx_remaining = state_reg.tx_left;
endmodule // slc_dma_chan

// ### core/slc_top.sv
// Function
// - dma acknowledge low during a cycle enables access to that channel's fifos
// - while acknowledged, address bits one to six are ignored; fifos are selected
// - address bit zero and byte enable choose byte or word fifo access
// - swap bit exchanges receive and transmit data pin roles
// - receive clock pin: rx clock mode 0, shared clock 1/5, baud clock 2/3
// - rts control bit set drives rts low
// - after rts bit clears, rts stays low until transmitter idle
// - bus mode: rts low during frame transmission, one clock late, no collision bits
// - bus mode: rts low during frame reception, or held high
// - transmitter enabled only while clear-to-send is low
// - optional interrupt on any clear-to-send change
// - bus mode: collision data input detects collisions on the shared bus
// - carrier detect is a modem or general input in modes 0,2,3,4,6,7
// - with auto-start: receiver enable, strobe in mode 1, frame sync in mode 5
// - optional interrupt on any carrier detect change
// - transmit data pin drives serial data, push-pull or open drain
// - nrzi with idle fill and rts bit clear ors rts into transmit data
// - transmit dma request active while fifo needs data, drops on last write
// - receive dma request active while fifo needs reads, drops after last read
module slc_top (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_srst,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic o_pready,
	output logic [31:0] o_prdata,
	output logic o_pslverr,
	// interrupt
	output logic o_irq,
	// parallel bus dma path
	input wire logic i_dma_ack_chan_a_n,
	input wire logic i_dma_ack_chan_b_n,
	input wire slc_pkg::slc_pbus_s i_pbus,
	output logic [1:0] o_fifo_access,
	output logic [1:0] o_fifo_word,
	output logic [1:0] o_fifo_high_byte,
	output logic o_tx_dma_request_a,
	output logic o_tx_dma_request_b,
	output logic o_rx_dma_request_a,
	output logic o_rx_dma_request_b,
	// fifo status from the channel cores, index 0 is channel a
	input wire logic [1:0] i_tx_fifo_need,
	input wire logic [1:0] i_rx_fifo_need,
	input wire logic [slc_pkg::SLC_BLK_W-1:0] i_rx_block_bytes_a,
	input wire logic [slc_pkg::SLC_BLK_W-1:0] i_rx_block_bytes_b,
	// serial core signals
	input wire logic [1:0] i_tx_serial,
	input wire logic [1:0] i_tx_active,
	input wire logic [1:0] i_tx_pending,
	input wire logic [1:0] i_tx_collision_bit,
	input wire logic [1:0] i_rx_frame,
	output logic [1:0] o_rx_data,
	output logic [1:0] o_tx_enable,
	output logic [1:0] o_rx_clock,
	output logic [1:0] o_txrx_clock,
	output logic [1:0] o_brg_clock,
	output logic [1:0] o_cd_input,
	output logic [1:0] o_rx_enable,
	output logic [1:0] o_rx_strobe,
	output logic [1:0] o_frame_sync,
	// line pins
	input wire logic i_rx_line_clock_a,
	input wire logic i_rx_line_clock_b,
	input wire logic [1:0] i_cts_n,
	input wire logic [1:0] i_carrier_detect,
	input wire logic i_collision_data_in_a,
	input wire logic i_collision_data_in_b,
	input wire logic [1:0] i_rxd_pin,
	input wire logic [1:0] i_txd_pin,
	output logic [1:0] o_rxd_pin_out,
	output logic [1:0] o_rxd_pin_oe,
	output logic [1:0] o_txd_pin_out,
	output logic [1:0] o_txd_pin_oe,
	output logic [1:0] o_rts_n
);
	// ----------------------------------------
	// register state
	// ----------------------------------------
	typedef struct packed {
		logic [1:0] rts_bit;
		slc_pkg::slc_ccr_s ccr_b;
		slc_pkg::slc_ccr_s ccr_a;
		logic [slc_pkg::SLC_INT_W-1:0] int_stat;
		logic [slc_pkg::SLC_INT_W-1:0] int_en;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic irq;
	} slc_top_state_s;

	slc_top_state_s state_reg, state_next;
	slc_pkg::slc_ccr_s ccr [2];
	logic [1:0] count_load;
	logic [slc_pkg::SLC_CNT_W-1:0] tx_left [2];
	logic [slc_pkg::SLC_EVT_W-1:0] events [2];
	logic [1:0] dma_ack_n;
	logic [1:0] rx_line_clock;
	logic [1:0] collision_in;
	logic [1:0] tx_req;
	logic [1:0] rx_req;
	logic [slc_pkg::SLC_BLK_W-1:0] rx_block [2];
	logic setup;
	logic wr_take;
	logic [7:0] chan_ofs;
	logic chan_sel;
	logic [slc_pkg::SLC_INT_W-1:0] ev_all;
	logic [slc_pkg::SLC_INT_W-1:0] clr_mask;

	assign ccr[0] = state_reg.ccr_a;
	assign ccr[1] = state_reg.ccr_b;
	assign dma_ack_n = {i_dma_ack_chan_b_n, i_dma_ack_chan_a_n};
	assign rx_line_clock = {i_rx_line_clock_b, i_rx_line_clock_a};
	assign collision_in = {i_collision_data_in_b, i_collision_data_in_a};
	assign rx_block[0] = i_rx_block_bytes_a;
	assign rx_block[1] = i_rx_block_bytes_b;

	// ----------------------------------------
	// apb decode and register update
	// ----------------------------------------
	// zero-wait slave: read data and pready are prepared in the setup cycle
	always_comb begin
		state_next = state_reg;
		setup = i_psel && !i_penable;
		wr_take = i_psel && i_penable && state_reg.pready && i_pwrite;
		chan_sel = i_paddr >= slc_pkg::SLC_CHAN_STRIDE && i_paddr < slc_pkg::SLC_OFS_INT_STAT;
		chan_ofs = chan_sel ? i_paddr - slc_pkg::SLC_CHAN_STRIDE : i_paddr;
		count_load = 2'b00;
		clr_mask = '0;
		state_next.pready = setup;
		if (setup) begin
			state_next.pslverr = 1'b0;
			state_next.prdata = slc_pkg::SLC_RDATA_RST;
			case (chan_ofs)
				slc_pkg::SLC_OFS_MODE_A:
					state_next.prdata[slc_pkg::SLC_MODE_RTS_BIT] = state_reg.rts_bit[chan_sel];
				slc_pkg::SLC_OFS_CHANNEL_CONFIG_TWO_A:
					state_next.prdata[slc_pkg::SLC_CCR_W-1:0] = ccr[chan_sel];
				slc_pkg::SLC_OFS_TXCNT_A:
					state_next.prdata[slc_pkg::SLC_CNT_W-1:0] = tx_left[chan_sel];
				slc_pkg::SLC_OFS_INT_STAT:
					state_next.prdata[slc_pkg::SLC_INT_W-1:0] = state_reg.int_stat;
				slc_pkg::SLC_OFS_INT_CLR: ; // write only, reads zero
				slc_pkg::SLC_OFS_INT_EN:
					state_next.prdata[slc_pkg::SLC_INT_W-1:0] = state_reg.int_en;
				slc_pkg::SLC_OFS_LINE_STAT:
					state_next.prdata[9:0] = {o_rts_n, o_cd_input, i_cts_n, tx_req, rx_req};
				default: state_next.pslverr = 1'b1;
			endcase
		end else begin
			state_next.pslverr = 1'b0; // error answer stands only with pready
		end
		// writes take effect in the access cycle with pready high
		if (wr_take && !state_reg.pslverr) begin
			case (chan_ofs)
				slc_pkg::SLC_OFS_MODE_A:
					state_next.rts_bit[chan_sel] = i_pwdata[slc_pkg::SLC_MODE_RTS_BIT];
				slc_pkg::SLC_OFS_CHANNEL_CONFIG_TWO_A: begin
					if (chan_sel)
						state_next.ccr_b = i_pwdata[slc_pkg::SLC_CCR_W-1:0];
					else
						state_next.ccr_a = i_pwdata[slc_pkg::SLC_CCR_W-1:0];
				end
				slc_pkg::SLC_OFS_TXCNT_A: count_load[chan_sel] = 1'b1;
				slc_pkg::SLC_OFS_INT_CLR: clr_mask = i_pwdata[slc_pkg::SLC_INT_W-1:0];
				slc_pkg::SLC_OFS_INT_EN:
					state_next.int_en = i_pwdata[slc_pkg::SLC_INT_W-1:0];
				default: ;
			endcase
		end
		// sticky events: a new event in the clear cycle survives
		ev_all = {events[1], events[0]};
		state_next.int_stat = (state_reg.int_stat & ~clr_mask) | ev_all;
		state_next.irq = |(state_next.int_stat & state_next.int_en);
	end

	// register state
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			state_reg <= '0;
			state_reg.prdata <= slc_pkg::SLC_RDATA_RST;
			state_reg.int_stat <= slc_pkg::SLC_INT_RST;
			state_reg.int_en <= slc_pkg::SLC_INT_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_pready = state_reg.pready;
	assign o_prdata = state_reg.prdata;
	assign o_pslverr = state_reg.pslverr;
	assign o_irq = state_reg.irq;

	// ----------------------------------------
	// channel instances
	// ----------------------------------------
	// one copy of each per channel; the count loads straight from the write data
	for (genvar ch = 0; ch < 2; ch++) begin : g_chan
		slc_line_chan u_line (
			.i_mclk(i_mclk),
			.i_srst(i_srst),
			.i_ccr(ccr[ch]),
			.i_rts_bit(state_reg.rts_bit[ch]),
			.i_tx_serial(i_tx_serial[ch]),
			.i_tx_active(i_tx_active[ch]),
			.i_tx_pending(i_tx_pending[ch]),
			.i_tx_collision_bit(i_tx_collision_bit[ch]),
			.i_rx_frame(i_rx_frame[ch]),
			.i_rx_line_clock(rx_line_clock[ch]),
			.i_cts_n(i_cts_n[ch]),
			.i_carrier_detect(i_carrier_detect[ch]),
			.i_collision_data_in(collision_in[ch]),
			.i_rxd_pin(i_rxd_pin[ch]),
			.i_txd_pin(i_txd_pin[ch]),
			.o_rxd_pin_out(o_rxd_pin_out[ch]),
			.o_rxd_pin_oe(o_rxd_pin_oe[ch]),
			.o_txd_pin_out(o_txd_pin_out[ch]),
			.o_txd_pin_oe(o_txd_pin_oe[ch]),
			.o_rts_n(o_rts_n[ch]),
			.o_rx_data(o_rx_data[ch]),
			.o_tx_enable(o_tx_enable[ch]),
			.o_rx_clock(o_rx_clock[ch]),
			.o_txrx_clock(o_txrx_clock[ch]),
			.o_brg_clock(o_brg_clock[ch]),
			.o_cd_input(o_cd_input[ch]),
			.o_rx_enable(o_rx_enable[ch]),
			.o_rx_strobe(o_rx_strobe[ch]),
			.o_frame_sync(o_frame_sync[ch]),
			.o_events(events[ch])
		);

		slc_dma_chan u_dma (
			.i_mclk(i_mclk),
			.i_srst(i_srst),
			.i_dma_ack_n(dma_ack_n[ch]),
			.i_pbus(i_pbus),
			.i_count_load(count_load[ch]),
			.i_count_value(i_pwdata[slc_pkg::SLC_CNT_W-1:0]),
			.i_tx_fifo_need(i_tx_fifo_need[ch]),
			.i_rx_fifo_need(i_rx_fifo_need[ch]),
			.i_rx_block_bytes(rx_block[ch]),
			.o_fifo_access(o_fifo_access[ch]),
			.o_fifo_word(o_fifo_word[ch]),
			.o_fifo_high_byte(o_fifo_high_byte[ch]),
			.o_tx_request(tx_req[ch]),
			.o_rx_request(rx_req[ch]),
			.o_tx_remaining(tx_left[ch])
		);
	end

	assign o_tx_dma_request_a = tx_req[0];
	assign o_tx_dma_request_b = tx_req[1];
	assign o_rx_dma_request_a = rx_req[0];
	assign o_rx_dma_request_b = rx_req[1];
endmodule // slc_top

// ### sim/slc_sva.sv
// channel a pins of the line and dma blocks; apb handshake as well
module slc_sva (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_srst,
	// apb and dma path
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic i_dma_ack_chan_a_n,
	input wire slc_pkg::slc_pbus_s i_pbus,
	input wire logic [1:0] o_fifo_access,
	input wire logic [1:0] o_fifo_word,
	input wire logic [1:0] o_fifo_high_byte,
	input wire logic [1:0] i_tx_fifo_need,
	input wire logic o_tx_dma_request_a,
	// line side
	input wire logic [1:0] i_cts_n,
	input wire logic [1:0] o_tx_enable,
	input wire logic [1:0] i_rxd_pin,
	input wire logic [1:0] o_rx_data,
	input wire logic [1:0] o_txd_pin_oe,
	input wire logic i_rx_line_clock_a,
	input wire logic [1:0] o_brg_clock
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_srst);
	// zero wait states; an error answer never comes alone
	a_apb_ready: assert property (i_psel && !i_penable |=> o_pready)
		else $error("pready missing after setup");
	a_apb_slverr: assert property (o_pslverr |-> o_pready)
		else $error("pslverr without pready");
	// acknowledge plus strobe opens the fifo one cycle later
	a_fifo_open: assert property (
		!i_dma_ack_chan_a_n && (i_pbus.rd || i_pbus.wr) |=> o_fifo_access[0])
		else $error("fifo access missing");
	a_fifo_word: assert property (
		!i_dma_ack_chan_a_n && i_pbus.wr && !i_pbus.addr0 && !i_pbus.byte_high_low_enable_n
		|=> o_fifo_word[0]) else $error("word access missing");
	a_fifo_high: assert property (
		!i_dma_ack_chan_a_n && i_pbus.rd && i_pbus.addr0 |=> o_fifo_high_byte[0])
		else $error("high byte missing");
	// first edge after reset still shows the reset value, hence the guard
	a_cts_enable: assert property (
		!$past(i_srst) |-> o_tx_enable[0] == !$past(i_cts_n[0]))
		else $error("tx enable not following cts");
	a_rx_unswapped: assert property (
		o_txd_pin_oe[0] |-> o_rx_data[0] == $past(i_rxd_pin[0]))
		else $error("rx data not from rxd pin");
	a_brg_clock: assert property (o_brg_clock[0] |-> $past(i_rx_line_clock_a))
		else $error("baud clock without line clock");
	a_tx_request: assert property (o_tx_dma_request_a |-> $past(i_tx_fifo_need[0]))
		else $error("tx request without fifo need");
endmodule // slc_sva

// ### sim/slc_line_model.sv
// modem and shared bus beyond the data pins; the bus has a pull-up
module slc_line_model (
	// pins from the device
	input wire logic [1:0] i_txd_out,
	input wire logic [1:0] i_txd_oe,
	input wire logic [1:0] i_rxd_out,
	input wire logic [1:0] i_rxd_oe,
	// bench commands: another station pulls the bus low, modem data bit
	input wire logic i_jam,
	input wire logic i_rx_bit,
	// wire levels
	output logic [1:0] o_txd,
	output logic [1:0] o_rxd,
	output logic o_coll
);
	timeunit 1ns;
	timeprecision 1ps;
	// wired-and bus: released means pulled high, never the last value
	assign o_txd = ~((i_txd_oe & ~i_txd_out) | {1'b0, i_jam});
	assign o_rxd = (i_rxd_oe & i_rxd_out) | (~i_rxd_oe & {2{i_rx_bit}});
	// collision input listens to the shared bus
	assign o_coll = o_txd[0];
endmodule // slc_line_model

// ### sim/slc_top_tb.sv
module slc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_mclk, i_srst, psel, pen, pwr, ack, lclk, jam, rxb, pready, pslverr, irq, txr, rxr;
	logic coll, se;
	logic [7:0] pa;
	logic [31:0] pwd, prdata, rd;
	logic [1:0] tn, rn, ts, ta, tp, tc, rf, cts, cd, wtx, wrx, rts, txe, txo, txoe, rxo, rxoe;
	logic [1:0] rxc, trc, brg, stb, fs, rxe, rxdat;
	slc_pkg::slc_pbus_s pb;
	logic [2:0] md [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};
	logic [4:0] ex [5] = '{5'h10, 5'h0A, 5'h04, 5'h04, 5'h09};
	int err_total, checks_done;
	// 40 mhz
	initial begin
		i_mclk = 0;
		forever #12.5 i_mclk = ~i_mclk;
	end
	slc_top i_slc_top (.i_mclk, .i_srst, .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(pa), .i_pwdata(pwd), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
		.o_irq(irq), .i_dma_ack_chan_a_n(ack), .i_dma_ack_chan_b_n(1'b1), .i_pbus(pb),
		.o_fifo_access(), .o_fifo_word(), .o_fifo_high_byte(), .o_tx_dma_request_a(txr),
		.o_tx_dma_request_b(), .o_rx_dma_request_a(rxr), .o_rx_dma_request_b(),
		.i_tx_fifo_need(tn), .i_rx_fifo_need(rn), .i_rx_block_bytes_a(6'h01),
		.i_rx_block_bytes_b(6'h01), .i_tx_serial(ts), .i_tx_active(ta), .i_tx_pending(tp),
		.i_tx_collision_bit(tc), .i_rx_frame(rf), .o_rx_data(rxdat), .o_tx_enable(txe),
		.o_rx_clock(rxc), .o_txrx_clock(trc), .o_brg_clock(brg), .o_cd_input(),
		.o_rx_enable(rxe), .o_rx_strobe(stb), .o_frame_sync(fs), .i_rx_line_clock_a(lclk),
		.i_rx_line_clock_b(1'b0), .i_cts_n(cts), .i_carrier_detect(cd),
		.i_collision_data_in_a(coll), .i_collision_data_in_b(1'b1), .i_rxd_pin(wrx),
		.i_txd_pin(wtx), .o_rxd_pin_out(rxo), .o_rxd_pin_oe(rxoe), .o_txd_pin_out(txo),
		.o_txd_pin_oe(txoe), .o_rts_n(rts));
	slc_line_model i_slc_line_model (.i_txd_out(txo), .i_txd_oe(txoe), .i_rxd_out(rxo),
		.i_rxd_oe(rxoe), .i_jam(jam), .i_rx_bit(rxb), .o_txd(wtx), .o_rxd(wrx), .o_coll(coll));
	task give_verdict;
		if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("Error %0t got %h want %h", $time, g, e);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge i_mclk);
	endtask
	// one apb transfer; a wait that never sees pready ends the run
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge i_mclk);
		pen <= 1;
		n = 0;
		do begin
			@(posedge i_mclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			err_total++;
			give_verdict();
		end
		rd = prdata;
		se = pslverr;
		psel <= 0;
		pen <= 0;
		cyc(2);
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		apb(0, a, 0);
		chk(rd, e);
	endtask
	// one dma cycle on channel a: {rd, wr, addr0, byte enable}
	task dma(input logic [3:0] s);
		ack <= 0;
		pb <= s;
		cyc(1);
		ack <= 1;
		pb <= '0;
		cyc(2);
	endtask
	initial begin
		{psel, pen, pwr, pa, pwd, lclk, jam, rxb, pb, se, rd} = '0;
		{tn, rn, ts, ta, tp, tc, rf, cts, cd} = '0;
		{ack, i_srst} = 2'b11;
		err_total = 0;
		checks_done = 0;
		cyc(12);
		i_srst <= 0;
		rdc(slc_pkg::SLC_OFS_LINE_STAT, 32'h0000_0300);
		rdc(8'h3C, 0);
		chk(se, 1);
		apb(1, slc_pkg::SLC_OFS_MODE_A, 1);
		chk(rts[0], 0);
		ta <= 1;
		apb(1, slc_pkg::SLC_OFS_MODE_A, 0);
		chk(rts[0], 0);
		ta <= 0;
		tp <= 1;
		cyc(2);
		chk(rts[0], 0);
		tp <= 0;
		cyc(2);
		chk(rts[0], 1);
		// enabled cts change raises irq, masked carrier change only sets status
		apb(1, slc_pkg::SLC_OFS_INT_CLR, 32'h0000_003F);
		apb(1, slc_pkg::SLC_OFS_INT_EN, 1);
		cts <= 1;
		cd <= 1;
		cyc(3);
		chk({irq, txe[0]}, 2'b10);
		rdc(slc_pkg::SLC_OFS_INT_STAT, 3);
		apb(1, slc_pkg::SLC_OFS_INT_CLR, 1);
		chk(irq, 0);
		rdc(slc_pkg::SLC_OFS_INT_STAT, 2);
		cts <= 0;
		cyc(2);
		chk(txe[0], 1);
		// every pin role of the receive clock and carrier detect, auto-start on
		for (int i = 0; i < 5; i++) begin
			apb(1, slc_pkg::SLC_OFS_CHANNEL_CONFIG_TWO_A, 32'h0000_0080 | md[i]);
			lclk <= 1;
			cyc(2);
			chk({rxc[0], trc[0], brg[0], stb[0], fs[0]}, ex[i]);
			lclk <= 0;
		end
		rdc(slc_pkg::SLC_OFS_LINE_STAT, 32'h0000_0340);
		apb(1, slc_pkg::SLC_OFS_CHANNEL_CONFIG_TWO_A, 32'h0000_0080);
		cd <= 0;
		rxb <= 1;
		cyc(2);
		chk({rxe[0], rxdat[0]}, 2'b01);
		// bus configuration: open drain, rts follows the frame
		apb(1, slc_pkg::SLC_OFS_CHANNEL_CONFIG_TWO_A, 32'h0000_0030);
		ts <= 1;
		ta <= 1;
		cyc(4);
		chk({rts[0], txoe[0]}, 0);
		tc <= 1;
		cyc(4);
		chk(rts[0], 1);
		tc <= 0;
		apb(1, slc_pkg::SLC_OFS_INT_CLR, 32'h0000_003F);
		jam <= 1;
		cyc(3);
		jam <= 0;
		rdc(slc_pkg::SLC_OFS_INT_STAT, 4);
		ts <= 0;
		cyc(2);
		chk({txoe[0], txo[0]}, 2'b10);
		ta <= 0;
		rf <= 1;
		apb(1, slc_pkg::SLC_OFS_CHANNEL_CONFIG_TWO_A, 32'h0000_0050);
		chk(rts[0], 0);
		apb(1, slc_pkg::SLC_OFS_CHANNEL_CONFIG_TWO_A, 32'h0000_0070);
		chk(rts[0], 1);
		rf <= 0;
		// swapped pins: txd released, rxd carries transmit data
		apb(1, slc_pkg::SLC_OFS_CHANNEL_CONFIG_TWO_A, 32'h0000_0008);
		{jam, ts} <= 3'b111;
		cyc(2);
		chk({txoe[0], rxoe[0], rxo[0], rxdat[0]}, 4'b0110);
		{jam, ts} <= 3'b000;
		apb(1, slc_pkg::SLC_OFS_CHANNEL_CONFIG_TWO_A, 32'h0000_0300);
		chk(txo[0], 1);
		// three bytes: a word then a byte; the last write drops the request
		apb(1, slc_pkg::SLC_OFS_TXCNT_A, 3);
		tn <= 1;
		cyc(2);
		chk(txr, 1);
		dma(4'b0100);
		chk(txr, 1);
		dma(4'b0111);
		chk(txr, 0);
		rdc(slc_pkg::SLC_OFS_TXCNT_A, 0);
		rn <= 1;
		cyc(2);
		chk(rxr, 1);
		dma(4'b1011);
		chk(rxr, 0);
		give_verdict();
	end
endmodule // slc_top_tb
bind slc_top slc_sva i_slc_sva (.i_mclk, .i_srst, .i_psel, .i_penable, .o_pready, .o_pslverr,
	.i_dma_ack_chan_a_n, .i_pbus, .o_fifo_access, .o_fifo_word, .o_fifo_high_byte,
	.i_tx_fifo_need, .o_tx_dma_request_a, .i_cts_n, .o_tx_enable, .i_rxd_pin, .o_rx_data,
	.o_txd_pin_oe, .i_rx_line_clock_a, .o_brg_clock);
